/* File: rtl/sto_timeout_counters.sv */
// module: three smart card time-out counters with run-enable and flag handling
`timescale 1ns/1ps
module sto_timeout_counters (
   input  wire logic               clock,
   input  wire logic               rst_n,
   input  wire logic [1:0]         timer_select_field,
   input  sto_pkg::sto_ctrl_s      ctrl0,
   input  sto_pkg::sto_ctrl_s      ctrl1,
   input  sto_pkg::sto_ctrl_s      ctrl2,
   input  wire logic [2:0]         run_enable_set,
   input  wire logic [2:0]         run_enable_clr,
   input  wire logic [2:0]         flag_clr,
   input  wire logic               etu_tick,
   input  wire logic               rx_start_bit,
   input  wire logic               tx_start_bit,
   input  wire logic               card_reset_release,
   input  wire logic               answer_to_reset,
   output logic [2:0]              counter_run_enable,
   output logic [2:0]              counter_timeout_flag,
   output logic                    timeout_irq,
   output logic [23:0]             wide_timeout_counter,
   output logic [7:0]              narrow_timeout_counter_a,
   output logic [7:0]              narrow_timeout_counter_b
);
   // ==========================================
   // shared decode
   localparam int NC = sto_pkg::NUM_CNT;
   logic [NC-1:0]  run_q;
   logic [NC-1:0]  run_d;
   logic [NC-1:0]  flag_q;
   logic [NC-1:0]  flag_d;
   logic           irq_q;
   logic [NC-1:0]  expire;
   logic [NC-1:0]  atr_done;
   logic [23:0]    val0;
   logic [7:0]     val1;
   logic [7:0]     val2;
   logic [23:0]    val0_q;
   logic [7:0]     val1_q;
   logic [7:0]     val2_q;

   wire logic      avail = (timer_select_field != sto_pkg::TIMER_SEL_OFF); // R03
   wire logic [NC-1:0] run_rise = run_d & ~run_q;

   sto_pkg::sto_evt_s evt;
   // one driver for the whole event bundle, fields in declaration order
   assign evt = {etu_tick, rx_start_bit, tx_start_bit, card_reset_release, answer_to_reset};

   // run-enable: software set, hardware clear at expiry or answer
   assign run_d  = (run_q | run_enable_set) & ~run_enable_clr; // R05
   // flags: hardware set wins over software clear
   assign flag_d = (flag_q & ~flag_clr) | expire; // R09 R14

   // ==========================================
   // counters
   sto_counter #(.W(sto_pkg::WIDE_W), .HAS_ATR(1'b1)) u_cnt0 ( // R01 R06
      .clock       (clock),
      .rst_n       (rst_n),
      .avail       (avail),
      .enable      (run_q[0]),
      .enable_rise (run_rise[0]),
      .ctrl        (ctrl0),
      .evt         (evt),
      .expire      (expire[0]),
      .atr_done    (atr_done[0]),
      .value       (val0)
   );

   sto_counter #(.W(sto_pkg::NARROW_W), .HAS_ATR(1'b0)) u_cnt1 ( // R01
      .clock       (clock),
      .rst_n       (rst_n),
      .avail       (avail),
      .enable      (run_q[1]),
      .enable_rise (run_rise[1]),
      .ctrl        (ctrl1),
      .evt         (evt),
      .expire      (expire[1]),
      .atr_done    (atr_done[1]),
      .value       (val1)
   );

   sto_counter #(.W(sto_pkg::NARROW_W), .HAS_ATR(1'b0)) u_cnt2 ( // R01
      .clock       (clock),
      .rst_n       (rst_n),
      .avail       (avail),
      .enable      (run_q[2]),
      .enable_rise (run_rise[2]),
      .ctrl        (ctrl2),
      .evt         (evt),
      .expire      (expire[2]),
      .atr_done    (atr_done[2]),
      .value       (val2)
   );

   // ==========================================
   // registers
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         run_q  <= '0;
         flag_q <= '0;
         irq_q  <= 1'b0;
         val0_q <= sto_pkg::COUNT_RESET;
         val1_q <= '0;
         val2_q <= '0;
      end else begin
         run_q  <= run_d & ~expire & ~atr_done; // R09 R14 R15
         flag_q <= flag_d;
         irq_q  <= |flag_d; // R14
         val0_q <= val0;
         val1_q <= val1;
         val2_q <= val2;
      end
   end

   assign counter_run_enable       = run_q;
   assign counter_timeout_flag     = flag_q;
   assign timeout_irq              = irq_q;
   assign wide_timeout_counter     = val0_q;
   assign narrow_timeout_counter_a = val1_q;
   assign narrow_timeout_counter_b = val2_q;
endmodule

/* File: rtl/sto_pkg.sv */
// package: constants and types for the smart card time-out counters
// ==========================================
// Behaviour
// R01 - three independent down-counters: counter zero 24 bits, counters one and two 8 bits
// R02 - each counter starts on run-enable write, on a start bit or on card reset release, per mode
// R03 - software selects the counters through the two-bit timer select field first
// R04 - control word holds mode in bits 27:24 and count in 23:0 (8 bits narrow)
// R05 - run-enable bits 5, 6, 7 of alternate control start counters zero, one, two
// R06 - answer-to-reset mode exists on counter zero only
// R07 - time-out interval equals programmed count plus one tick
// R08 - mode 0000 counts as soon as run-enable is set
// R09 - modes 0000/0001 at zero set status flag 5:3 and clear run-enable
// R10 - mode 0001 starts at first start bit, received or transmitted
// R11 - mode 0010 starts at first received start bit only
// R12 - mode 0011 only times the answer-to-reset window during activation or warm reset
// R13 - mode 0011 starts at card reset release if run-enable was set before
// R14 - mode 0011 zero before answer sets status bit 3, interrupt, clears run-enable
// R15 - answer arriving with counter nonzero clears run-enable, no flag
// R16 - counters decrement once per elementary time unit, hold while disabled
package sto_pkg;
   localparam int WIDE_W   = 24;
   localparam int NARROW_W = 8;
   localparam int NUM_CNT  = 3;
   // control word field positions
   localparam int MODE_HI  = 27;
   localparam int MODE_LO  = 24;
   localparam int COUNT_HI = 23;
   localparam int COUNT_LO = 0;
   // run-enable bit positions in alternate control
   localparam int RUN0_BIT = 5;
   localparam int RUN1_BIT = 6;
   localparam int RUN2_BIT = 7;
   // time-out flag positions in interrupt status
   localparam int FLAG_LO  = 3;
   localparam int FLAG_HI  = 5;
   localparam logic [1:0] TIMER_SEL_OFF = 2'h0;
   localparam logic [WIDE_W-1:0] COUNT_RESET = 24'h000000;

   typedef enum logic [3:0] {
      STO_MODE_ENABLE = 4'h0,
      STO_MODE_ANY_START = 4'h1,
      STO_MODE_RX_START = 4'h2,
      STO_MODE_ATR = 4'h3
   } sto_mode_e;

   typedef enum logic [1:0] {
      STO_IDLE = 2'h0,
      STO_ARMED = 2'h1,
      STO_RUN = 2'h2
   } sto_state_e;

   // one counter's control word
   typedef struct packed {
      logic [3:0]        mode;
      logic [WIDE_W-1:0] count;
   } sto_ctrl_s;

   // line events seen by every counter
   typedef struct packed {
      logic tick;
      logic rx_start;
      logic tx_start;
      logic rst_release;
      logic atr_seen;
   } sto_evt_s;
endpackage

/* File: rtl/sto_counter.sv */
// module: one time-out down-counter with its start logic
`timescale 1ns/1ps
module sto_counter #(
   parameter int  W       = 24,
   parameter bit  HAS_ATR = 1'b0
) (
   input  wire logic              clock,
   input  wire logic              rst_n,
   input  wire logic              avail,
   input  wire logic              enable,
   input  wire logic              enable_rise,
   input  sto_pkg::sto_ctrl_s     ctrl,
   input  sto_pkg::sto_evt_s      evt,
   output logic                   expire,
   output logic                   atr_done,
   output logic [W-1:0]           value
);
   // ==========================================
   // state
   sto_pkg::sto_state_e state_q;
   sto_pkg::sto_state_e state_d;
   logic [W-1:0]        cnt_q;
   logic [W-1:0]        cnt_d;

   // ==========================================
   // decode
   wire logic [3:0] mode        = ctrl.mode;
   wire logic       m_enable    = (mode == 4'(sto_pkg::STO_MODE_ENABLE));
   wire logic       m_any       = (mode == 4'(sto_pkg::STO_MODE_ANY_START));
   wire logic       m_rx        = (mode == 4'(sto_pkg::STO_MODE_RX_START));
   wire logic       m_atr       = HAS_ATR && (mode == 4'(sto_pkg::STO_MODE_ATR)); // R06 R12
   wire logic       go_any      = m_any && (evt.rx_start || evt.tx_start); // R10
   wire logic       go_rx       = m_rx && evt.rx_start; // R11
   wire logic       go_atr      = m_atr && evt.rst_release; // R13
   wire logic       start_now   = go_any || go_rx || go_atr; // R02
   wire logic       at_zero     = (cnt_q == '0);
   wire logic       atr_abort   = m_atr && evt.atr_seen && !at_zero; // R15
   wire logic [W-1:0] load_val  = ctrl.count[W-1:0]; // R04

   // ==========================================
   // next state
   always_comb begin
      state_d  = state_q;
      cnt_d    = cnt_q;
      expire   = 1'b0;
      atr_done = 1'b0;
      case (state_q)
         sto_pkg::STO_IDLE: begin
            if (avail && enable_rise) begin
               cnt_d = load_val;
               if (m_enable)
                  state_d = sto_pkg::STO_RUN; // R08
               else
                  state_d = sto_pkg::STO_ARMED;
            end
         end
         sto_pkg::STO_ARMED: begin
            if (!enable || !avail)
               state_d = sto_pkg::STO_IDLE;
            else if (start_now)
               state_d = sto_pkg::STO_RUN;
         end
         sto_pkg::STO_RUN: begin
            if (!enable || !avail) begin
               state_d = sto_pkg::STO_IDLE; // R16
            end else if (atr_abort) begin
               atr_done = 1'b1;
               state_d  = sto_pkg::STO_IDLE;
            end else if (evt.tick) begin
               // zero reached after count ticks, expiry on the next tick (count+1 ticks)
               if (at_zero) begin
                  expire  = 1'b1; // R07 R09 R14
                  state_d = sto_pkg::STO_IDLE;
               end else begin
                  cnt_d = cnt_q - W'(1); // R16
               end
            end
         end
         default: state_d = sto_pkg::STO_IDLE;
      endcase
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= sto_pkg::STO_IDLE;
         cnt_q   <= '0;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
      end
   end

   assign value = cnt_q;
endmodule

/* File: sim/sto_card_model.sv */
// card side model: time unit ticks and line event pulses
`timescale 1ns/1ps
module sto_card_model #(
   parameter int ETU = 3
) (
   input  wire logic       clock,
   input  wire logic       rst_n,
   input  wire logic       ticking,
   input  wire logic [3:0] req,
   output logic            etu_tick,
   output logic [3:0]      evt
);
   // ==========
   // tick divider and event pulses
   logic [3:0] div_q;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         div_q <= 4'h0;
         etu_tick <= 1'b0;
         evt <= 4'h0;
      end else begin
         div_q <= (div_q == 4'(ETU - 1)) ? 4'h0 : div_q + 4'h1;
         etu_tick <= ticking && div_q == 4'h0;
         evt <= req;
      end
   end
endmodule

/* File: sim/sto_timeout_counters_asserts.sv */
// checker: port assertions for the time-out counters
`timescale 1ns/1ps
module sto_timeout_counters_asserts (
   input wire logic        clock,
   input wire logic        rst_n,
   input wire logic [1:0]  timer_select_field,
   input sto_pkg::sto_ctrl_s ctrl0,
   input wire logic [2:0]  run_enable_set,
   input wire logic [2:0]  flag_clr,
   input wire logic        answer_to_reset,
   input wire logic [2:0]  counter_run_enable,
   input wire logic [2:0]  counter_timeout_flag,
   input wire logic        timeout_irq,
   input wire logic [23:0] wide_timeout_counter
);
   // ==========
   // assertions
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   chk_irq_follows: assert property (timeout_irq == (|counter_timeout_flag))
      else $error("irq not following flags");
   chk_run_set: assert property (run_enable_set[0] && timer_select_field != 2'h0 |=> counter_run_enable[0])
      else $error("run enable not set");
   chk_flag_needs_run: assert property (!counter_run_enable[1] |=> !$rose(counter_timeout_flag[1]))
      else $error("flag rose while idle");
   chk_expiry_stops: assert property ($rose(counter_timeout_flag[0]) |-> $past(counter_run_enable[0]) && !counter_run_enable[0])
      else $error("expiry kept run enable");
   chk_flag_sticky: assert property (counter_timeout_flag[2] && !flag_clr[2] |=> counter_timeout_flag[2])
      else $error("flag dropped");
   chk_flag_clear: assert property (flag_clr[2] && !counter_run_enable[2] |=> !counter_timeout_flag[2])
      else $error("flag not cleared");
   chk_idle_hold: assert property (!counter_run_enable[0] [*4] |-> $stable(wide_timeout_counter))
      else $error("counter moved while idle");
   chk_answer_abort: assert property (answer_to_reset && counter_run_enable[0] && ctrl0.mode == 4'h3 && wide_timeout_counter > 24'h2 && !run_enable_set[0] |=> !counter_run_enable[0] && !$rose(counter_timeout_flag[0]))
      else $error("answer did not abort");
endmodule
bind sto_timeout_counters sto_timeout_counters_asserts u_chk (.clock, .rst_n, .timer_select_field, .ctrl0,
   .run_enable_set, .flag_clr, .answer_to_reset, .counter_run_enable, .counter_timeout_flag, .timeout_irq,
   .wide_timeout_counter);

/* File: sim/sto_timeout_counters_test.sv */
// testbench: row-driven and hand-written checks of the time-out counters
`timescale 1ns/1ps
module sto_timeout_counters_test;
   // ==========
   // signals
   typedef struct packed {
      logic [1:0]  idx;
      logic [3:0]  mode;
      logic [23:0] cnt;
      logic [3:0]  ev;
      logic [23:0] ticks;
   } sto_row_s;
   logic               clock = 1'b0;
   logic               rst_n, ticking, etu_tick, timeout_irq;
   logic [1:0]         timer_select_field;
   logic [2:0]         run_enable_set, run_enable_clr, flag_clr, counter_run_enable, counter_timeout_flag;
   logic [3:0]         req, evt;
   logic [23:0]        wide_timeout_counter;
   logic [7:0]         narrow_timeout_counter_a, narrow_timeout_counter_b;
   sto_pkg::sto_ctrl_s ctrl [3];
   int                 n_mismatch = 0;
   int                 n_compared = 0;
   int                 n;
   sto_row_s           rows [5] = '{
      '{2'h0, 4'h0, 24'h000005, 4'h0, 24'h000006},
      '{2'h1, 4'h1, 24'h000102, 4'h2, 24'h000003},
      '{2'h2, 4'h2, 24'h000000, 4'h1, 24'h000001},
      '{2'h0, 4'h3, 24'h000004, 4'h4, 24'h000005},
      '{2'h0, 4'h1, 24'h000100, 4'h1, 24'h000101}};
   always #20 clock = ~clock;
   sto_card_model card (.clock, .rst_n, .ticking, .req, .etu_tick, .evt);
   sto_timeout_counters DUT (.clock, .rst_n, .timer_select_field, .ctrl0(ctrl[0]), .ctrl1(ctrl[1]),
      .ctrl2(ctrl[2]), .run_enable_set, .run_enable_clr, .flag_clr, .etu_tick, .rx_start_bit(evt[0]),
      .tx_start_bit(evt[1]), .card_reset_release(evt[2]), .answer_to_reset(evt[3]), .counter_run_enable,
      .counter_timeout_flag, .timeout_irq, .wide_timeout_counter, .narrow_timeout_counter_a,
      .narrow_timeout_counter_b);
   // ==========
   // tasks
   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic finish_test();
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic fire(input logic [3:0] r, input logic [2:0] s, input logic [2:0] c, input logic [2:0] f);
      @(negedge clock);
      {req, run_enable_set, run_enable_clr, flag_clr} = {r, s, c, f};
      @(negedge clock);
      {req, run_enable_set, run_enable_clr, flag_clr} = 13'h0000;
   endtask
   task automatic run_ticks(input int i, input int lim);
      n = 0;
      ticking = 1'b1;
      for (int k = 0; k <= 1000; k++) begin
         @(negedge clock);
         if (counter_timeout_flag[i] === 1'b1 || n == lim) break;
         if (k == 1000) begin
            n_mismatch++;
            finish_test();
         end
         n += int'(etu_tick === 1'b1);
      end
      ticking = 1'b0;
   endtask
   // ==========
   // sequence
   initial begin
      rst_n = 1'b0;
      timer_select_field = 2'h1;
      ctrl = '{default: '0};
      {run_enable_set, run_enable_clr, flag_clr, req, ticking} = 14'h0000;
      repeat (8) @(negedge clock);
      rst_n = 1'b1;
      check(wide_timeout_counter, 24'h000000);
      check({16'h0000, narrow_timeout_counter_b}, 24'h000000);
      check({21'h000000, counter_timeout_flag}, 24'h000000);
      foreach (rows[r]) begin
         ctrl[rows[r].idx] = {rows[r].mode, rows[r].cnt};
         fire(4'h0, 3'h1 << rows[r].idx, 3'h0, 3'h0);
         fire(rows[r].ev, 3'h0, 3'h0, 3'h0);
         run_ticks(rows[r].idx, 300);
         check(24'(n), rows[r].ticks);
         check({23'h000000, counter_run_enable[rows[r].idx]}, 24'h000000);
         @(negedge clock);
         check({23'h000000, timeout_irq}, 24'h000001);
         fire(4'h0, 3'h0, 3'h0, 3'h1 << rows[r].idx);
      end
      ctrl[2] = {4'h2, 24'h000001};
      ctrl[1] = {4'h3, 24'h000001};
      fire(4'h0, 3'h6, 3'h0, 3'h0);
      fire(4'h6, 3'h0, 3'h0, 3'h0);
      run_ticks(2, 8);
      check(24'(n), 24'h000008);
      check({21'h000000, counter_timeout_flag}, 24'h000000);
      check({21'h000000, counter_run_enable}, 24'h000006);
      check({16'h0000, narrow_timeout_counter_a}, 24'h000001);
      check({16'h0000, narrow_timeout_counter_b}, 24'h000001);
      fire(4'h0, 3'h0, 3'h6, 3'h0);
      ctrl[0] = {4'h3, 24'h000040};
      fire(4'h0, 3'h1, 3'h0, 3'h0);
      fire(4'h4, 3'h0, 3'h0, 3'h0);
      run_ticks(0, 4);
      fire(4'h8, 3'h0, 3'h0, 3'h0);
      repeat (2) @(negedge clock);
      check({21'h000000, counter_run_enable}, 24'h000000);
      check({21'h000000, counter_timeout_flag}, 24'h000000);
      check(wide_timeout_counter, 24'h00003C);
      timer_select_field = 2'h0;
      ctrl[0] = {4'h0, 24'h000000};
      fire(4'h0, 3'h1, 3'h0, 3'h0);
      run_ticks(0, 4);
      check({21'h000000, counter_timeout_flag}, 24'h000000);
      fire(4'h0, 3'h0, 3'h1, 3'h0);
      finish_test();
   end
endmodule
